//--- hdl/irq_flag_map.svh
/*
 * Register offsets, field positions and reset values of the interrupt flag block.
 * Assumes it is included by its bare name from design files that need the map.
 */
`ifndef IRQ_FLAG_MAP_SVH
`define IRQ_FLAG_MAP_SVH

// Byte offsets on the internal data bus.
`define PEND_HIGH_OFF    8'h08
`define ENABLE_HIGH_OFF  8'h09
`define PEND_LOW_OFF     8'h2c
`define ENABLE_LOW_OFF   8'h2d

// Reset values of all four registers.
`define PEND_RESET       8'h00
`define ENABLE_RESET     8'h00
`define RDATA_IDLE       8'h00

// Field positions in the high pending register.
`define HIGH_REQ2_BIT    7
`define HIGH_REQ1_BIT    6
`define HIGH_TMR2_BIT    5
`define HIGH_TMR1_BIT    4

`endif

//--- hdl/irq_flag_pkg.sv
/*
 * Types shared by the interrupt flag block.
 * Assumes nothing of its surroundings.
 */
package irq_flag_pkg;

   // One access on the internal data bus.
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } bus_req_t;

   // Pending or enable bits of both registers, high register in the upper byte.
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } flag_pair_t;

endpackage

//--- hdl/pin_edge_sync.sv
/*
 * Two-stage synchroniser with rise and fall detection for one pin.
 * Assumes the pin is asynchronous to clk_i; outputs are on the clk_i domain.
 */
module pin_edge_sync (
   input  wire logic clk_i,     // Processor phase clock.
   input  wire logic rstn_i,    // Synchronous reset, active low.
   input  wire logic pin_i,     // Raw pin level.
   output logic      level_o,   // Synchronised level.
   output logic      rise_o,    // One-cycle pulse on a low-to-high change.
   output logic      fall_o     // One-cycle pulse on a high-to-low change.
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // The first stage is read only by the second; idle-high reset avoids a false fall.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         last_q <= 1'b1;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edges are judged only from the settled stages.
   assign level_o = sync_q;
   assign rise_o  = sync_q & ~last_q;
   assign fall_o  = ~sync_q & last_q;

endmodule // pin_edge_sync

//--- hdl/irq_flag_logic.sv
/*
 * Interrupt flag logic: two pending registers fed by port pin edges, level requests
 * and timer events, two enable registers, and a fixed-priority vector selector.
 * Assumes pins and requests are asynchronous, timer events are clk_i pulses, and the
 * core reads rdata_o one cycle after a read strobe.
 */
// Overview of operation
// [R1] Level request sets its flag on falling edge, held set while the request stays low.
// [R2] Edge sources set their flag only on a change to their own polarity.
// [R3] Edge capture tolerates pin changes at any moment relative to the clock.
// [R4] Reading a pending register returns its contents without touching the flags.
// [R5] Writing one clears a flag once; later events may set it again.
// [R6] Writing zero leaves a flag bit as it was.
// [R7] Among pending enabled flags the highest bit number selects the vector.
// [R8] Any high-register bit outranks every low-register bit.
// [R9] Low bits 7,6 fall on port 5 pins 3,2; bits 5,4 rise on pins 1,0.
// [R10] Low bits 3,2 fall on port 4 pins 7,6; bits 1,0 rise on pins 5,4.
// [R11] A flag raises the interrupt only while its enable bit is one.
// [R12] A set arriving with a clear in one cycle keeps the flag set.
// [R13] Both pending registers are zero after reset.
`include "irq_flag_map.svh"

module irq_flag_logic
   import irq_flag_pkg::*;
(
   input  wire logic       clk_i,                 // Processor phase clock, 100 MHz.
   input  wire logic       rstn_i,                // Synchronous reset, active low.
   input  wire bus_req_t   bus_i,                 // Internal data bus request.
   input  wire logic [7:0] port4_i,               // Port 4 pins, only 7..4 used.
   input  wire logic [7:0] port5_i,               // Port 5 pins.
   input  wire logic [1:0] external_request_n_i,  // Level requests 2 and 1, active low.
   input  wire logic [1:0] timer_edge_i,          // Timer 2 and 1 event pulses.
   output logic [7:0]      rdata_o,               // Read data, one cycle after rd.
   output logic            irq_o,                 // Interrupt request to the core.
   output logic [3:0]      vector_o               // Index of the winning flag, 15 highest.
);
   localparam int NPIN = 14;

   flag_pair_t pend_q;
   flag_pair_t pend_d;
   flag_pair_t en_q;
   flag_pair_t set_w;
   flag_pair_t clr_w;
   logic [15:0] active_w;
   logic [NPIN-1:0] pins_w;
   logic [NPIN-1:0] lvl_w;
   logic [NPIN-1:0] rise_w;
   logic [NPIN-1:0] fall_w;
   logic [7:0] rdata_q;
   logic       irq_q;
   logic [3:0] vec_q;

   // Returns the highest set bit index of a 16-bit vector.
   function automatic logic [3:0] top_bit(input logic [15:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   // True when the bus targets the given offset.
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction

   // Pin order: 13..12 requests, 11..4 port 5 pins 7..0, 3..0 port 4 pins 7..4.
   assign pins_w = {external_request_n_i, port5_i, port4_i[7:4]};

   // Every asynchronous source is synchronised before its edge is judged. [R3]
   for (genvar g = 0; g < NPIN; g++) begin : g_sync
      pin_edge_sync u_sync (
         .clk_i   (clk_i),
         .rstn_i  (rstn_i),
         .pin_i   (pins_w[g]),
         .level_o (lvl_w[g]),
         .rise_o  (rise_w[g]),
         .fall_o  (fall_w[g])
      );
   end

   // Set terms; a request held low keeps asserting its flag. [R1] [R2] [R9] [R10]
   always_comb begin
      set_w.low[7]  = fall_w[7];                       // [R9]
      set_w.low[6]  = fall_w[6];                       // [R9]
      set_w.low[5]  = rise_w[5];                       // [R9]
      set_w.low[4]  = rise_w[4];                       // [R9]
      set_w.low[3]  = fall_w[3];                       // [R10]
      set_w.low[2]  = fall_w[2];                       // [R10]
      set_w.low[1]  = rise_w[1];                       // [R10]
      set_w.low[0]  = rise_w[0];                       // [R10]
      set_w.high[`HIGH_REQ2_BIT] = fall_w[13] | ~lvl_w[13]; // [R1]
      set_w.high[`HIGH_REQ1_BIT] = fall_w[12] | ~lvl_w[12]; // [R1]
      set_w.high[`HIGH_TMR2_BIT] = timer_edge_i[1];
      set_w.high[`HIGH_TMR1_BIT] = timer_edge_i[0];
      set_w.high[3] = fall_w[11];                      // [R2]
      set_w.high[2] = rise_w[10];                      // [R2]
      set_w.high[1] = rise_w[9];                       // [R2]
      set_w.high[0] = rise_w[8];                       // [R2]
   end

   // Write-one clear pulses last only the write cycle; zeros clear nothing. [R5] [R6]
   always_comb begin
      clr_w.high = (bus_i.wr && hit(bus_i.addr, `PEND_HIGH_OFF)) ? bus_i.wdata : 8'h00;
      clr_w.low  = (bus_i.wr && hit(bus_i.addr, `PEND_LOW_OFF)) ? bus_i.wdata : 8'h00;
   end

   // Set is applied after the clear so a coincident event survives. [R12]
   assign pend_d = (pend_q & ~clr_w) | set_w;

   // Pending registers. [R13]
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pend_q <= {`PEND_RESET, `PEND_RESET};
      end else begin
         pend_q <= pend_d;
      end
   end

   // Enable registers are plain read/write storage.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         en_q <= {`ENABLE_RESET, `ENABLE_RESET};
      end else if (bus_i.wr) begin
         if (hit(bus_i.addr, `ENABLE_HIGH_OFF)) begin
            en_q.high <= bus_i.wdata;
         end
         if (hit(bus_i.addr, `ENABLE_LOW_OFF)) begin
            en_q.low <= bus_i.wdata;
         end
      end
   end

   // Reads have no side effect; unmapped offsets read zero. [R4]
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rdata_q <= `RDATA_IDLE;
      end else if (bus_i.rd) begin
         case (bus_i.addr)
            `PEND_HIGH_OFF:   rdata_q <= pend_q.high;
            `PEND_LOW_OFF:    rdata_q <= pend_q.low;
            `ENABLE_HIGH_OFF: rdata_q <= en_q.high;
            `ENABLE_LOW_OFF:  rdata_q <= en_q.low;
            default:          rdata_q <= `RDATA_IDLE;
         endcase
      end
   end

   // Only enabled flags compete; the high byte sits above the low byte. [R11] [R8]
   assign active_w = pend_q & en_q;

   // Highest active bit number wins; registered so outputs come from flops. [R7]
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         irq_q <= 1'b0;
         vec_q <= 4'h0;
      end else begin
         irq_q <= |active_w;
         vec_q <= top_bit(active_w);
      end
   end

   assign rdata_o  = rdata_q;
   assign irq_o    = irq_q;
   assign vector_o = vec_q;

   // All checks run on the processor phase clock; all but reset_zero_a rest while reset is held.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // Request 2 held low must keep its flag up in every following cycle.
   level_hold_a: assert property (!lvl_w[13] |=> pend_q.high[7]) // [R1]
      else $error("Request 2 low but flag not held");

   // A flag may only rise in the cycle after one of its set terms was present.
   no_spurious_a: assert property ( // [R2]
      1'b1 |=> ((pend_q & ~$past(pend_q) & ~$past(set_w)) == 16'h0000))
      else $error("Flag rose without a set event");

   // A read returns the old contents and leaves the flags to their set terms.
   read_clean_a: assert property ( // [R4]
      (bus_i.rd && bus_i.addr == `PEND_LOW_OFF && !bus_i.wr)
      |=> rdata_o == $past(pend_q.low)
          && pend_q.low == ($past(pend_q.low) | $past(set_w.low)))
      else $error("Pending read wrong or disturbed flags");

   // A written one must drop its flag unless a set term met it in that cycle.
   clear_one_a: assert property ( // [R5]
      (bus_i.wr && bus_i.addr == `PEND_HIGH_OFF)
      |=> (pend_q.high & $past(bus_i.wdata) & ~$past(set_w.high)) == 8'h00)
      else $error("Write one did not clear the flag");

   // Written zeros must leave their flags as they were, barring a new set.
   zero_keep_a: assert property ( // [R6]
      (bus_i.wr && bus_i.addr == `PEND_LOW_OFF)
      |=> (pend_q.low & ~$past(bus_i.wdata)) == ($past(pend_q.low) & ~$past(bus_i.wdata))
          || (($past(set_w.low) & ~$past(bus_i.wdata)) != 8'h00))
      else $error("Written zero changed a flag");

   // A set term meeting a clear in the same cycle must win, so no event is lost.
   set_wins_a: assert property ( // [R12]
      (set_w != 16'h0000) |=> (pend_q & $past(set_w)) == $past(set_w))
      else $error("Set event lost");

   // Every port 5 pin 3..0 edge detector must land in its own upper low-register bit.
   port5_map_a: assert property ( // [R9]
      {fall_w[7], fall_w[6], rise_w[5], rise_w[4]} != 4'h0
      |=> (pend_q.low[7:4] & $past({fall_w[7], fall_w[6], rise_w[5], rise_w[4]}))
          == $past({fall_w[7], fall_w[6], rise_w[5], rise_w[4]}))
      else $error("Port 5 edge not recorded");

   // Every port 4 edge detector must land in its own lower low-register bit.
   port4_map_a: assert property ( // [R10]
      {fall_w[3], fall_w[2], rise_w[1], rise_w[0]} != 4'h0
      |=> (pend_q.low[3:0] & $past({fall_w[3], fall_w[2], rise_w[1], rise_w[0]}))
          == $past({fall_w[3], fall_w[2], rise_w[1], rise_w[0]}))
      else $error("Port 4 edge not recorded");

   // The vector must name the highest flag that was active one cycle earlier.
   prio_top_a: assert property (irq_o |-> ($past(active_w) >> vector_o) == 16'h0001) // [R7]
      else $error("Vector is not the highest active flag");

   // Any active high-register flag must pull the vector into the upper half.
   high_rank_a: assert property ( // [R8]
      ($past(active_w[15:8]) != 8'h00) && irq_o |-> vector_o[3])
      else $error("Low register outranked high register");

   // With nothing enabled and pending the request must drop.
   enable_gate_a: assert property ((active_w == 16'h0000) |=> !irq_o) // [R11]
      else $error("Interrupt without enabled flag");

   // Reset must empty both pending registers and drop the request.
   reset_zero_a: assert property (@(posedge clk_i) disable iff (1'b0) // [R13]
      !rstn_i |=> pend_q == 16'h0000 && !irq_o)
      else $error("Flags not cleared by reset");

endmodule // irq_flag_logic

//--- tb/core_model.sv
/*
 * Core-side model: issues one access at a time on the internal data bus.
 * Assumes one clk_i domain and that access is called just after a rising edge.
 */
module core_model
   import irq_flag_pkg::*;
(
   input  wire logic clk_i,    // Processor phase clock.
   output bus_req_t  bus_o,    // Bus request to the flag block.
   output logic      valid_o   // High in the cycle that read data is due.
);
   timeunit 1ns;
   timeprecision 1ps;

   initial bus_o = '0;

   // Read data is due one cycle after the strobe edge.
   always_ff @(posedge clk_i) valid_o <= bus_o.rd;

   // The strobe stands for one edge; released lines show inverted values, never stale ones.
   task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
      bus_o <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk_i);
      bus_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
endmodule // core_model

//--- tb/testbench.sv
/*
 * Self-checking bench for the interrupt flag logic: pins, requests, timer pulses,
 * register reads and clears, enables and the priority vector.
 * Assumes the core model drives the bus and all other inputs come from here.
 */
module testbench;
   import irq_flag_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk_i = 1'b0;
   logic       rstn_i = 1'b0;
   bus_req_t   bus;
   logic [7:0] port4_i = 8'hff;
   logic [7:0] port5_i = 8'hff;
   logic [1:0] req_n = 2'b11;
   logic [1:0] tmr = 2'b00;
   logic [7:0] rdata, m, en, lowf;
   logic       irq, valid;
   logic [3:0] vec;
   logic [7:0] exp_q[$];
   int         failures = 0, n_checks = 0, cyc = 0, seed = 32'hfba9;

   always #5 clk_i = ~clk_i;

   irq_flag_logic irq_flag_logic_inst (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus),
      .port4_i(port4_i), .port5_i(port5_i), .external_request_n_i(req_n),
      .timer_edge_i(tmr), .rdata_o(rdata), .irq_o(irq), .vector_o(vec));
   core_model core_model_inst (.clk_i(clk_i), .bus_o(bus), .valid_o(valid));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (failures == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Each read leaves its expected value queued; the monitor below consumes it.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      core_model_inst.access(a, 1'b0, 8'h00);
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      core_model_inst.access(a, 1'b1, d);
      @(posedge clk_i);
   endtask

   // Low bits 7..4 sit on port 5 pins 3..0, bits 3..0 on port 4 pins 7..4.
   task automatic pin(input int b, input logic v);
      if (b > 3) port5_i[b-4] <= v;
      else port4_i[b+4] <= v;
      repeat (5) @(posedge clk_i);
   endtask

   function automatic logic [7:0] top_bit(input logic [7:0] x);
      top_bit = 8'h00;
      for (int i = 0; i < 8; i++) if (x[i]) top_bit = i[7:0];
   endfunction

   // Settled read data is compared away from the edge that updates it.
   always @(negedge clk_i) if (valid === 1'b1) check("rdata", rdata, exp_q.pop_front());

   // A hang is cut short well beyond the length of the sequence.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      rd(8'h08, 8'h00);
      rd(8'h2c, 8'h00);
      rd(8'h55, 8'h00);
      for (int b = 0; b < 8; b++) begin
         pin(b, 1'b0);
         rd(8'h2c, b[1] ? 8'h01 << b : 8'h00);
         pin(b, 1'b1);
         rd(8'h2c, 8'h01 << b);
         rd(8'h2c, 8'h01 << b);
         wr(8'h2c, 8'hff);
      end
      for (int b = 0; b < 8; b++) pin(b, 1'b0);
      for (int b = 0; b < 8; b++) pin(b, 1'b1);
      m = 8'($random(seed));
      wr(8'h2c, m);
      rd(8'h2c, ~m);
      pin(0, 1'b0);
      pin(0, 1'b1);
      lowf = ~m | 8'h01;
      rd(8'h2c, lowf);
      wr(8'h09, 8'h00);
      for (int k = 0; k < 4; k++) begin
         en = 8'($random(seed)) | 8'h01;
         wr(8'h2d, en);
         rd(8'h2d, en);
         check("irq", {7'h00, irq}, 8'h01);
         check("vector", {4'h0, vec}, top_bit(lowf & en));
      end
      tmr <= 2'b01;
      @(posedge clk_i);
      tmr <= 2'b00;
      wr(8'h09, 8'h10);
      rd(8'h09, 8'h10);
      @(posedge clk_i);
      check("vector", {4'h0, vec}, 8'h0c);
      wr(8'h09, 8'h00);
      wr(8'h2d, 8'h00);
      // The request register needs one more edge to follow the cleared enable.
      @(posedge clk_i);
      check("irq", {7'h00, irq}, 8'h00);
      wr(8'h08, 8'hff);
      req_n <= 2'b00;
      repeat (5) @(posedge clk_i);
      rd(8'h08, 8'hc0);
      wr(8'h08, 8'hc0);
      rd(8'h08, 8'hc0);
      req_n <= 2'b11;
      repeat (5) @(posedge clk_i);
      wr(8'h08, 8'hc0);
      rd(8'h08, 8'h00);
      tmr <= 2'b11;
      core_model_inst.access(8'h08, 1'b1, 8'h30);
      tmr <= 2'b00;
      @(posedge clk_i);
      rd(8'h08, 8'h30);
      // Port 5 pins 7..4: only pin 7 counts falls, pins 6..4 count rises.
      port5_i[7:4] <= 4'h0;
      repeat (5) @(posedge clk_i);
      rd(8'h08, 8'h38);
      port5_i[7:4] <= 4'hf;
      repeat (5) @(posedge clk_i);
      rd(8'h08, 8'h3f);
      repeat (3) @(posedge clk_i);
      tally_and_finish();
   end
endmodule // testbench
